// ### rtl/pulse_seq_pkg.sv
package pulse_seq_pkg;

    // ****************************************
    // Sizes and register map
    // ****************************************
    localparam int TIME_W  = 48;
    localparam int FREQ_W  = 32;
    localparam int LEVEL_W = 16;
    localparam int PHASE_W = 16;

    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h1;
    localparam logic [3:0] ADDR_TIME_LO   = 4'h2;
    localparam logic [3:0] ADDR_RF_FREQ   = 4'h3;
    localparam logic [3:0] ADDR_RF_LEVEL  = 4'h4;
    localparam logic [3:0] ADDR_EDGE_TIME = 4'h5;
    localparam logic [3:0] ADDR_ERRORS    = 4'h6;

    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_GATE_BIT  = 1;
    localparam int CTRL_SHAPE_BIT = 2;

    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 16'h0000;

    // Offset limit: 1 GHz in Hz (offset field is signed Hz)
    localparam logic signed [FREQ_W-1:0] FREQ_OFS_LIMIT = 32'sh3b9a_ca00;

    // Sample rate is 2.4 GHz; continuous joins need multiples of 8 samples
    localparam int CONCAT_GRAIN = 8;

    localparam logic [1:0] CMD_FREQ  = 2'h1;
    localparam logic [1:0] CMD_LEVEL = 2'h2;
    localparam logic [1:0] CMD_BOTH  = 2'h3;

    // ****************************************
    // Descriptor carriers
    // ****************************************
    typedef struct packed {
        logic                      isControl;
        logic [TIME_W-1:0]         arrivalTime;
        logic [31:0]               pulseOnTime;
        logic signed [FREQ_W-1:0]  freqOffset;
        logic [LEVEL_W-1:0]        levelAtten;
        logic [PHASE_W-1:0]        phaseOffset;
        logic                      phaseRelative;
        logic [1:0]                cmdType;
        logic [1:0]                rfPath;
        logic [FREQ_W-1:0]         newFreq;
        logic [LEVEL_W-1:0]        newLevel;
    } descriptor_s;

    typedef struct packed {
        logic                      active;
        logic signed [FREQ_W-1:0]  freqOffset;
        logic [LEVEL_W-1:0]        levelAtten;
        logic [PHASE_W-1:0]        phase;
        logic                      phaseReset;
    } pulse_out_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_PULSE = 3'b100
    } seq_state_e;

endpackage

// ### rtl/desc_buffer.sv
`timescale 1ns/1ps
module desc_buffer
    import pulse_seq_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        inValid,
    output      logic        inReady,
    input  wire descriptor_s inData,
    output      logic        outValid,
    input  wire logic        outReady,
    output      descriptor_s outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        descriptor_s [DEPTH-1:0] mem;
        logic [PW-1:0]           rdPtr;
        logic [PW-1:0]           wrPtr;
        logic [PW:0]             count;
    } buf_s;

    buf_s bufReg;
    buf_s bufNext;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign inReady  = (bufReg.count != (PW+1)'(DEPTH));
    assign outValid = (bufReg.count != '0);
    assign outData  = bufReg.mem[bufReg.rdPtr];

    always_comb begin
        logic doWr;
        logic doRd;
        doWr = inValid && inReady;
        doRd = outValid && outReady;
        bufNext = bufReg;
        if (doWr) begin
            bufNext.mem[bufReg.wrPtr] = inData;
            bufNext.wrPtr = bump(bufReg.wrPtr);
        end
        if (doRd) begin
            bufNext.rdPtr = bump(bufReg.rdPtr);
        end
        if (doWr && !doRd) begin
            bufNext.count = bufReg.count + 1'b1;
        end else if (doRd && !doWr) begin
            bufNext.count = bufReg.count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bufReg <= '0;
        end else begin
            bufReg <= bufNext;
        end
    end

    // Full refuses, so a stalled reader loses no word
    no_overflow_a: assert property (@(posedge sys_clk) disable iff (rst)
        bufReg.count == (PW+1)'(DEPTH) && !outReady |=> !inReady && $stable(outData))
        else $error("stalled buffer lost a word");
endmodule

// ### rtl/pulse_descriptor_sequencer.sv
`timescale 1ns/1ps
// Contract
// R1: Arrival times are integer counts of 2.4 GHz sample clock cycles.
// R2: Accept per-pulse frequency offset within plus or minus 1 GHz.
// R3: Level offset is relative; realised as digital baseband attenuation.
// R4: Control descriptor is sixteen bytes: time, path, command, frequency/level.
// R5: Apply control frequency or level change at its arrival time.
// R6: Supplier leaves settling time before the next pulse descriptor.
// R7: Retune discards earlier emitter phase; phase restarts discontinuous.
// R8: Relative phase mode with zero offset continues the running phase.
// R9: Supplier makes concatenated on-time a multiple of eight samples.
// R10: Back-to-back pulses join end directly to next start.
// R11: Gate marker drives modulator only when enabled in configuration.
// R12: Gate rises at arrival, falls after on-time, plus edges if shaped.
// R13: Descriptors consumed in order; arrival times never decrease.
module pulse_descriptor_sequencer
    import pulse_seq_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output      logic [31:0] regRdData,
    input  wire logic        descValid,
    output      logic        descReady,
    input  wire descriptor_s descData,
    output      pulse_out_s  pulseOut,
    output      logic        gateMarker,
    output      logic [FREQ_W-1:0]  rfFreq,
    output      logic [LEVEL_W-1:0] rfLevel,
    output      logic [1:0]  rfPath,
    output      logic        rfUpdate
);

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        seq_state_e          state;
        logic [31:0]         ctrl;
        logic [TIME_W-1:0]   timeNow;
        logic [31:0]         onLeft;
        logic [31:0]         gateLeft;
        logic [15:0]         edgeTime;
        logic [FREQ_W-1:0]   rfFreq;
        logic [LEVEL_W-1:0]  rfLevel;
        logic [1:0]          rfPath;
        logic                rfUpdate;
        logic                gate;
        logic [PHASE_W-1:0]  phase;
        logic                phaseReset;
        logic                retuned;
        logic                active;
        logic signed [FREQ_W-1:0] freqOffset;
        logic [LEVEL_W-1:0]  levelAtten;
        logic [TIME_W-1:0]   lastTime;
        logic [15:0]         rangeErrs;
        logic [15:0]         orderErrs;
        logic [31:0]         rdData;
    } seq_s;

    seq_s r_reg;
    seq_s r_next;

    descriptor_s head;
    logic        headValid;
    logic        headTake;

    desc_buffer #(
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inValid  (descValid),
        .inReady  (descReady),
        .inData   (descData),
        .outValid (headValid),
        .outReady (headTake),
        .outData  (head)
    );

    function automatic logic inRange(input logic signed [FREQ_W-1:0] f);
        return (f <= FREQ_OFS_LIMIT) && (f >= -FREQ_OFS_LIMIT);
    endfunction

    function automatic logic [15:0] sat16(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    logic running;
    logic due;
    assign running = r_reg.ctrl[CTRL_RUN_BIT];
    // Due once the sample counter reaches the arrival count
    assign due = headValid && running && (r_reg.timeNow >= head.arrivalTime); // [R1]
    // Take when due; a pulse is only taken from the last cycle of the previous on-time on
    assign headTake = due && (head.isControl || r_reg.onLeft <= 32'h1); // [R13] [R10]

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [31:0] gateExtra;
        gateExtra = r_reg.ctrl[CTRL_SHAPE_BIT] ? {15'h0, r_reg.edgeTime, 1'b0} : 32'h0;
        r_next = r_reg;
        r_next.rfUpdate = 1'b0;
        r_next.phaseReset = 1'b0;
        r_next.rdData = 32'h0;
        if (running) begin
            r_next.timeNow = r_reg.timeNow + 1'b1;
        end
        if (r_reg.onLeft != 32'h0) begin
            r_next.onLeft = r_reg.onLeft - 1'b1;
        end
        if (r_reg.gateLeft != 32'h0) begin
            r_next.gateLeft = r_reg.gateLeft - 1'b1;
        end
        if (r_reg.onLeft <= 32'h1) begin
            r_next.active = 1'b0;
        end
        r_next.gate = (r_next.gateLeft != 32'h0) && r_reg.ctrl[CTRL_GATE_BIT]; // [R11]

        case (r_reg.state)
            ST_IDLE: begin
                if (running) begin
                    r_next.state = ST_WAIT;
                end
            end
            ST_WAIT, ST_PULSE: begin
                if (!running) begin
                    r_next.state = ST_IDLE;
                end else if (r_reg.onLeft > 32'h1) begin
                    r_next.state = ST_PULSE;
                end else begin
                    r_next.state = ST_WAIT;
                end
            end
            default: r_next.state = ST_IDLE;
        endcase

        // Clear first so that an error in the same cycle still counts
        if (regWrite && regAddr == ADDR_ERRORS) begin
            r_next.rangeErrs = 16'h0;
            r_next.orderErrs = 16'h0;
        end
        if (headTake) begin
            if (head.arrivalTime < r_reg.lastTime) begin
                r_next.orderErrs = sat16(r_next.orderErrs); // [R13]
            end
            r_next.lastTime = head.arrivalTime;
            if (head.isControl) begin
                // New carrier takes effect at the descriptor's arrival time
                if (head.cmdType == CMD_FREQ || head.cmdType == CMD_BOTH) begin
                    r_next.rfFreq = head.newFreq; // [R4] [R5]
                    r_next.retuned = 1'b1; // [R7]
                end
                if (head.cmdType == CMD_LEVEL || head.cmdType == CMD_BOTH) begin
                    r_next.rfLevel = head.newLevel; // [R5]
                end
                r_next.rfPath = head.rfPath;
                r_next.rfUpdate = 1'b1;
            end else if (!inRange(head.freqOffset)) begin
                r_next.rangeErrs = sat16(r_next.rangeErrs); // [R2]
            end else begin
                r_next.active = 1'b1;
                r_next.state = ST_PULSE;
                r_next.onLeft = head.pulseOnTime; // [R10]
                r_next.gateLeft = head.pulseOnTime + gateExtra; // [R12]
                r_next.gate = r_reg.ctrl[CTRL_GATE_BIT]; // [R11] [R12]
                r_next.freqOffset = head.freqOffset; // [R2]
                r_next.levelAtten = head.levelAtten; // [R3]
                if (r_reg.retuned) begin
                    // No phase memory across a retune
                    r_next.phase = head.phaseOffset; // [R7]
                    r_next.phaseReset = 1'b1;
                    r_next.retuned = 1'b0;
                end else if (head.phaseRelative) begin
                    r_next.phase = r_reg.phase + head.phaseOffset; // [R8]
                end else begin
                    r_next.phase = head.phaseOffset;
                    r_next.phaseReset = 1'b1;
                end
            end
        end

        // ****************************************
        // Register port
        // ****************************************
        if (regWrite) begin
            if (regAddr == ADDR_CTRL) begin
                r_next.ctrl = regWrData;
            end else if (regAddr == ADDR_EDGE_TIME) begin
                r_next.edgeTime = regWrData[15:0];
            end
        end
        if (regRead) begin
            if (regAddr == ADDR_CTRL) begin
                r_next.rdData = r_reg.ctrl;
            end else if (regAddr == ADDR_STATUS) begin
                r_next.rdData = {26'h0, r_reg.state, headValid, r_reg.gate, r_reg.active};
            end else if (regAddr == ADDR_TIME_LO) begin
                r_next.rdData = r_reg.timeNow[31:0];
            end else if (regAddr == ADDR_RF_FREQ) begin
                r_next.rdData = r_reg.rfFreq;
            end else if (regAddr == ADDR_RF_LEVEL) begin
                r_next.rdData = {16'h0, r_reg.rfLevel};
            end else if (regAddr == ADDR_EDGE_TIME) begin
                r_next.rdData = {16'h0, r_reg.edgeTime};
            end else if (regAddr == ADDR_ERRORS) begin
                r_next.rdData = {r_reg.orderErrs, r_reg.rangeErrs};
            end else begin
                r_next.rdData = 32'h0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.ctrl <= CTRL_RESET;
            r_reg.rfFreq <= FREQ_RESET;
            r_reg.rfLevel <= LEVEL_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign regRdData = r_reg.rdData;
    assign gateMarker = r_reg.gate;
    assign rfFreq = r_reg.rfFreq;
    assign rfLevel = r_reg.rfLevel;
    assign rfPath = r_reg.rfPath;
    assign rfUpdate = r_reg.rfUpdate;
    assign pulseOut = '{active: r_reg.active, freqOffset: r_reg.freqOffset,
                        levelAtten: r_reg.levelAtten, phase: r_reg.phase,
                        phaseReset: r_reg.phaseReset};

    // ****************************************
    // Checks
    // ****************************************
    ctrl_on_time_a: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
        headTake && head.isControl && head.cmdType == CMD_FREQ
        |=> rfUpdate && rfFreq == $past(head.newFreq))
        else $error("retune not applied at arrival");

    not_early_a: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
        headTake |-> r_reg.timeNow >= head.arrivalTime)
        else $error("descriptor taken before its arrival time");

    gate_off_a: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
        !r_reg.ctrl[CTRL_GATE_BIT] ##1 !r_reg.ctrl[CTRL_GATE_BIT] |-> !gateMarker)
        else $error("gate marker while disabled");

    gate_rise_a: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
        headTake && !head.isControl && inRange(head.freqOffset)
        && r_reg.ctrl[CTRL_GATE_BIT] && head.pulseOnTime != 0 |=> gateMarker)
        else $error("gate marker did not rise at arrival");

    range_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
        headTake && !head.isControl && !inRange(head.freqOffset)
        |=> r_reg.rangeErrs != 16'h0)
        else $error("out of range offset not counted");

    phase_cont_a: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
        headTake && !head.isControl && inRange(head.freqOffset) && !r_reg.retuned
        && head.phaseRelative && head.phaseOffset == '0 |=> $stable(pulseOut.phase))
        else $error("running phase not continued");

    retune_phase_a: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
        headTake && !head.isControl && inRange(head.freqOffset) && r_reg.retuned
        |=> pulseOut.phaseReset && !r_reg.retuned)
        else $error("phase kept across retune");

    atten_load_a: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
        headTake && !head.isControl && inRange(head.freqOffset)
        |=> pulseOut.levelAtten == $past(head.levelAtten) && rfLevel == $past(rfLevel))
        else $error("level offset not applied as attenuation");

    join_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
        r_reg.onLeft > 32'h1 |-> !headTake || head.isControl)
        else $error("pulse started over a running one");

    in_order_a: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
        headTake && head.arrivalTime < r_reg.lastTime |=> r_reg.orderErrs != 16'h0)
        else $error("order fault not counted");

    ctrl_word_a: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
        headTake && head.isControl && head.cmdType == CMD_LEVEL
        |=> rfLevel == $past(head.newLevel) && rfPath == $past(head.rfPath))
        else $error("control word fields not applied");

    time_step_a: assert property ( // [R1]
        running |=> r_reg.timeNow == $past(r_reg.timeNow) + 1'b1)
        else $error("sample count stuck");

    time_hold_a: assert property ( // [R1]
        !running |=> $stable(r_reg.timeNow))
        else $error("count moved while stopped");

    active_hold_a: assert property ( // [R10]
        r_reg.active && r_reg.onLeft > 32'h1 |=> r_reg.active)
        else $error("pulse ended early");

    active_end_a: assert property ( // [R10]
        r_reg.onLeft <= 32'h1 && !headTake |=> !r_reg.active)
        else $error("pulse ran long");

    gate_hold_a: assert property ( // [R12]
        r_reg.gateLeft > 32'h1 && r_reg.ctrl[CTRL_GATE_BIT] && !headTake |=> gateMarker)
        else $error("gate fell early");

    gate_end_a: assert property ( // [R12]
        r_reg.gateLeft <= 32'h1 && !headTake |=> !gateMarker)
        else $error("gate held long");

    abs_phase_a: assert property ( // [R8]
        headTake && !head.isControl && inRange(head.freqOffset) && !head.phaseRelative
        |=> pulseOut.phaseReset && pulseOut.phase == $past(head.phaseOffset))
        else $error("absolute phase not set");

    range_keep_a: assert property ( // [R2]
        headTake && !head.isControl && !inRange(head.freqOffset)
        |=> $stable(pulseOut.freqOffset) && $stable(pulseOut.levelAtten))
        else $error("dropped pulse shown");

    err_clear_a: assert property ( // [R13]
        regWrite && regAddr == ADDR_ERRORS && !headTake
        |=> r_reg.rangeErrs == 16'h0 && r_reg.orderErrs == 16'h0)
        else $error("errors not cleared");

    update_once_a: assert property ( // [R5]
        !(headTake && head.isControl) |=> !rfUpdate)
        else $error("stray carrier update");
endmodule

// ### test/desc_source.sv
`timescale 1ns/1ps
module desc_source
    import pulse_seq_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    output logic       descValid,
    input  wire logic  descReady,
    output descriptor_s descData
);
    // ****************************************
    // Simulator side of the descriptor stream
    // ****************************************
    descriptor_s q[$];
    bit          slow = 1'b0;
    int          gap  = 0;

    initial begin
        descValid = 1'b0;
        descData  = '0;
    end

    // Words leave in queue order, times given in sample counts
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            descValid <= 1'b0;
        end else if (descValid && descReady) begin
            void'(q.pop_front());
            if (!slow && q.size() > 0) begin
                descData <= q[0];
            end else begin
                descValid <= 1'b0;
                // A released bus must not keep showing the old word
                descData  <= ~descData;
                gap       <= slow ? int'($urandom_range(3)) : 0;
            end
        end else if (!descValid && gap > 0) begin
            gap <= gap - 1;
        end else if (!descValid && q.size() > 0) begin
            descValid <= 1'b1;
            descData  <= q[0];
        end
    end
endmodule

// ### test/pulse_descriptor_sequencer_test.sv
`timescale 1ns/1ps
module pulse_descriptor_sequencer_test
    import pulse_seq_pkg::*;
;
    // ****************************************
    // Stimulus, monitor and checks
    // ****************************************
    logic               sys_clk;
    logic               rst;
    logic [3:0]         regAddr;
    logic [31:0]        regWrData;
    logic               regWrite;
    logic               regRead;
    logic [31:0]        regRdData;
    logic               descValid;
    logic               descReady;
    descriptor_s        descData;
    pulse_out_s         pulseOut;
    logic               gateMarker;
    logic [FREQ_W-1:0]  rfFreq;
    logic [LEVEL_W-1:0] rfLevel;
    logic [1:0]         rfPath;
    logic               rfUpdate;
    int                 fails, compares, activeCnt, gateCnt, updCnt, rises, falls;
    bit                 actPrev;
    logic [31:0]        firstOfs, r, eF, eL;
    logic [15:0]        firstLvl, firstPh, lastPh, lastLvl;
    logic [47:0]        t0;

    pulse_descriptor_sequencer #(.BUF_DEPTH(2)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .descValid(descValid), .descReady(descReady), .descData(descData),
        .pulseOut(pulseOut), .gateMarker(gateMarker), .rfFreq(rfFreq), .rfLevel(rfLevel),
        .rfPath(rfPath), .rfUpdate(rfUpdate));

    desc_source i_src (.sys_clk(sys_clk), .rst(rst), .descValid(descValid),
        .descReady(descReady), .descData(descData));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (pulseOut.active === 1'b1) begin
            activeCnt++;
            if (!actPrev) begin
                rises++;
                firstOfs = pulseOut.freqOffset;
                firstLvl = pulseOut.levelAtten;
                firstPh  = pulseOut.phase;
            end
            lastPh  = pulseOut.phase;
            lastLvl = pulseOut.levelAtten;
        end else if (actPrev) begin
            falls++;
        end
        actPrev = (pulseOut.active === 1'b1);
        if (gateMarker === 1'b1) gateCnt++;
        if (rfUpdate === 1'b1) updCnt++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge sys_clk);
        regWrite  <= 1'b0;
    endtask

    task automatic regRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic clr();
        {activeCnt, gateCnt, updCnt, rises, falls} = '0;
    endtask

    task automatic tnow(output logic [47:0] t);
        logic [31:0] v;
        regRd(ADDR_TIME_LO, v);
        t = 48'(v) + 48'd40;
    endtask

    task automatic waitFalls(input int n);
        for (int i = 0; i < 3000; i++) begin
            @(posedge sys_clk);
            if (falls >= n && gateMarker === 1'b0) return;
        end
        fails++;
        summarize();
    endtask

    function automatic descriptor_s mk(input logic [47:0] t, input int on,
                                       input logic [31:0] ofs, input logic [15:0] lvl,
                                       input logic [15:0] ph, input logic rel);
        descriptor_s d;
        d               = '0;
        d.arrivalTime   = t;
        d.pulseOnTime   = 32'(on);
        d.freqOffset    = ofs;
        d.levelAtten    = lvl;
        d.phaseOffset   = ph;
        d.phaseRelative = rel;
        return d;
    endfunction

    function automatic logic [31:0] nextVal(input logic [1:0] c, input logic [1:0] want,
                                            input logic [31:0] old, input logic [31:0] nw);
        return (c == want || c == CMD_BOTH) ? nw : old;
    endfunction

    task automatic pulse(input logic [31:0] ofs, input logic [15:0] lvl, input int on,
                         input int gateExp);
        tnow(t0);
        clr();
        i_src.q.push_back(mk(t0, on, ofs, lvl, 16'h0000, 1'b0));
        waitFalls(1);
        check(32'(activeCnt), 32'(on));
        check(32'(gateCnt), 32'(gateExp));
        check(firstOfs, ofs);
        check(32'(firstLvl), 32'(lvl));
    endtask

    initial begin
        {regAddr, regWrData, regWrite, regRead, fails, compares, eF, eL} = '0;
        clr();
        rst = 1'b1;
        void'($urandom(32'h195a9b39));
        repeat (10) @(posedge sys_clk);
        #1 check({regRdData[28:0], gateMarker, rfUpdate, descReady}, 32'h1);
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        regRd(ADDR_CTRL, r);
        check(r, CTRL_RESET);
        regWr(ADDR_RF_FREQ, 32'h1234_5678);
        regRd(ADDR_RF_FREQ, r);
        check(r, 32'(FREQ_RESET));
        regRd(ADDR_RF_LEVEL, r);
        check(r, 32'(LEVEL_RESET));
        regRd(4'hf, r);
        check(r, 32'h0);
        $display("test registers done");
        regWr(ADDR_CTRL, 32'h3);
        pulse(FREQ_OFS_LIMIT, 16'h0010, 5, 5);
        pulse(-FREQ_OFS_LIMIT, 16'h0200, 1, 1);
        regWr(ADDR_CTRL, 32'h1);
        pulse(32'h0, 16'h0000, 4, 0);
        regWr(ADDR_EDGE_TIME, 32'h3);
        regWr(ADDR_CTRL, 32'h7);
        pulse(32'h64, 16'h0001, 6, 12);
        regWr(ADDR_CTRL, 32'h3);
        for (int i = 0; i < 6; i++) begin
            int on;
            on = int'($urandom_range(1, 12));
            pulse(32'(int'($urandom_range(2000000000)) - 1000000000),
                  16'($urandom), on, on);
        end
        $display("test pulses done");
        regWr(ADDR_ERRORS, 32'h0);
        tnow(t0);
        clr();
        i_src.q.push_back(mk(t0, 4, FREQ_OFS_LIMIT + 1, 16'h0, 16'h0, 1'b0));
        i_src.q.push_back(mk(t0 - 48'd1, 4, 32'h0, 16'h0, 16'h0, 1'b0));
        for (int i = 0; i < 40 && r < 32'(t0) + 32'd8; i++) regRd(ADDR_TIME_LO, r);
        if (r < 32'(t0) + 32'd8) begin
            fails++;
            summarize();
        end
        check(32'(activeCnt), 32'h4);
        regRd(ADDR_ERRORS, r);
        check(r, 32'h0001_0001);
        $display("test range done");
        tnow(t0);
        clr();
        i_src.q.push_back(mk(t0, 8, 32'h0, 16'h0000, 16'h0, 1'b1));
        i_src.q.push_back(mk(t0 + 48'd8, 8, 32'h0, 16'h0020, 16'h0, 1'b1));
        waitFalls(1);
        check(32'(activeCnt), 32'd16);
        check(32'(rises), 32'h1);
        check(32'(lastPh), 32'(firstPh));
        check(32'(lastLvl), 32'h20);
        $display("test back to back done");
        for (int c = 1; c < 4; c++) begin
            descriptor_s w;
            tnow(t0);
            clr();
            w = mk(t0 + 48'd10, 0, 32'h0, 16'h0, 16'h0, 1'b0);
            w.isControl = 1'b1;
            w.cmdType   = 2'(c);
            w.rfPath    = 2'(c);
            w.newFreq   = $urandom;
            w.newLevel  = 16'($urandom);
            eF = nextVal(2'(c), CMD_FREQ, eF, w.newFreq);
            eL = nextVal(2'(c), CMD_LEVEL, eL, 32'(w.newLevel));
            i_src.q.push_back(mk(t0, 4, 32'h0, 16'h0, 16'h0100, 1'b0));
            i_src.q.push_back(w);
            i_src.q.push_back(mk(t0 + 48'd30, 4, 32'h0, 16'h0, 16'h1234, 1'b1));
            waitFalls(2);
            check(32'(updCnt), 32'h1);
            check(rfFreq, eF);
            check(32'(rfLevel), eL);
            check(32'(rfPath), 32'(c));
            if (c != 2) check(32'(firstPh), 32'h1234);
            else check(32'(firstPh), 32'h1334);
        end
        $display("test control done");
        regWr(ADDR_CTRL, 32'h0);
        tnow(t0);
        clr();
        for (int i = 0; i < 3; i++) i_src.q.push_back(mk(t0 + 48'(10 * i), 4, 0, 0, 0, 0));
        for (int i = 0; i < 20 && descReady !== 1'b0; i++) @(posedge sys_clk);
        #1 check(32'(descReady), 32'h0);
        if (descReady !== 1'b0) begin
            fails++;
            summarize();
        end
        check(32'(i_src.q.size()), 32'h1);
        i_src.slow = 1'b1;
        regWr(ADDR_CTRL, 32'h3);
        waitFalls(3);
        check(32'(rises), 32'h3);
        $display("test buffer done");
        summarize();
    end
endmodule
